/* core/ccn_pkg.sv */
// Purpose: Shared constants and types of the clock network control block
// Assumes: One system clock; APB3 slave with 32-bit data
// Notes:   Source index map: 0-3 left/right side pins, 4-11 top/bottom pins,
//          12-19 PLL outputs, 20 internal logic
package ccn_pkg;

    // ********************************
    // Sizes
    // ********************************
    localparam int NUM_GLOBAL   = 16;
    localparam int NUM_REGIONAL = 32;
    localparam int NUM_QUAD     = 4;
    localparam int QUAD_LINES   = 8;
    localparam int NUM_PIN      = 12;
    localparam int NUM_PLL      = 4;
    localparam int NUM_PLL_OUT  = 8;
    localparam int NUM_BASE_SRC = 20;
    localparam int QUAD_RES     = 24;
    localparam int ROW_CLKS     = 6;
    localparam int GROUP_CLKS   = 3;
    localparam int NUM_PAIR     = 4;
    localparam int NUM_PINOUT   = 2;
    localparam int ADDR_W       = 12;

    // ********************************
    // Source index map
    // ********************************
    localparam logic [4:0] SRC_LR_HI    = 5'h03;
    localparam logic [4:0] SRC_TB_LO    = 5'h04;
    localparam logic [4:0] SRC_TB_HI    = 5'h0B;
    localparam logic [4:0] SRC_PLL_BASE = 5'h0C;
    localparam logic [4:0] SRC_CORE     = 5'h14;
    localparam logic [3:0] FAST_PLL_MASK   = 4'h3;
    localparam logic [3:0] CORNER_PLL_MASK = 4'h8;

    // Pair n joins quadrant PAIR_QA[n] and PAIR_QB[n]
    localparam logic [3:0][1:0] PAIR_QA   = {2'h1, 2'h0, 2'h2, 2'h0};
    localparam logic [3:0][1:0] PAIR_QB   = {2'h3, 2'h2, 2'h3, 2'h1};
    localparam logic [3:0]      PAIR_VERT = 4'hC;

    // ********************************
    // Register offsets
    // ********************************
    localparam logic [ADDR_W-1:0] OFS_GSEL   = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_RSEL   = 12'h040;
    localparam logic [ADDR_W-1:0] OFS_PAIR   = 12'h0C0;
    localparam logic [ADDR_W-1:0] OFS_ROWSEL = 12'h0D0;
    localparam logic [ADDR_W-1:0] OFS_GRPSEL = 12'h0E0;
    localparam logic [ADDR_W-1:0] OFS_POUT   = 12'h0F0;
    localparam logic [ADDR_W-1:0] OFS_GSTAT  = 12'h100;
    localparam logic [ADDR_W-1:0] OFS_RSTAT  = 12'h104;
    localparam logic [ADDR_W-1:0] OFS_END    = 12'h108;

    // ********************************
    // Register layouts (reset value of all is zero: nets off)
    // ********************************
    typedef struct packed {
        logic       on;
        logic       dynMode;
        logic [4:0] dynB;
        logic [4:0] dynA;
        logic [4:0] sel;
    } ccn_gcfg_t;

    typedef struct packed {
        logic       on;
        logic [4:0] sel;
    } ccn_rcfg_t;

    typedef struct packed {
        logic [4:0] src;
        logic [2:0] line;
        logic       en;
    } ccn_pair_t;

    typedef struct packed {
        logic       useInternal;
        logic       on;
        logic [2:0] sel;
    } ccn_pout_t;

    typedef logic [ROW_CLKS-1:0][4:0]   ccn_rowsel_t;
    typedef logic [GROUP_CLKS-1:0][2:0] ccn_grpsel_t;

    typedef struct packed {
        logic [4:0] idx;
        logic       gate;
    } ccn_step_t;

    typedef enum logic [3:0] {
        K_NONE, K_GSEL, K_RSEL, K_PAIR, K_ROW, K_GRP, K_POUT, K_GSTAT, K_RSTAT
    } ccn_kind_t;

    typedef struct packed {
        ccn_kind_t  kind;
        logic [4:0] idx;
    } ccn_dec_t;

    // Inputs from outside the clock domain, synchronised together
    typedef struct packed {
        logic                    userMode;
        logic [NUM_PINOUT-1:0]   pinInternal;
        logic [NUM_PINOUT-1:0]   pDynEn;
        logic [NUM_REGIONAL-1:0] rDynEn;
        logic [NUM_GLOBAL-1:0]   gDynEn;
        logic [NUM_GLOBAL-1:0]   gDynSel;
        logic [NUM_REGIONAL-1:0] coreRegional;
        logic [NUM_GLOBAL-1:0]   coreGlobal;
        logic [NUM_PLL_OUT-1:0]  pllOut;
        logic [NUM_PIN-1:0]      clkPin;
    } ccn_in_t;

endpackage

/* core/ccn_clock_network_control.sv */
// Purpose: Clock network control: source select and gating of global,
//          regional and PLL output pin nets, plus row group clock picks
// Assumes: Clock sources are sampled on clk_sys; nets are rebuilt from samples
//
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ccn_clock_network_control
    import ccn_pkg::*;
(
    input  wire logic                          clk_sys,
    input  wire logic                          nrst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire ccn_in_t                       srcIn,
    output logic      [NUM_GLOBAL-1:0]         globalClockNet,
    output logic      [NUM_REGIONAL-1:0]       regionalClockNet,
    output logic      [NUM_QUAD*GROUP_CLKS-1:0] logicRowGroupClk,
    output logic      [NUM_PINOUT-1:0]         pllPin
);

    // ********************************
    // Functions
    // ********************************
    function automatic logic srcAt(input logic [NUM_BASE_SRC-1:0] base,
                                   input logic core, input logic [4:0] idx);
        logic lvl;
        lvl = 1'b0;
        if (idx == SRC_CORE) begin
            lvl = core;
        end else if (idx < SRC_CORE) begin
            lvl = base[idx];
        end
        return lvl;
    endfunction

    // Move the mux and the gate only while the levels involved are low
    function automatic ccn_step_t ccStep(input ccn_step_t cur, input logic [4:0] want,
                                         input logic wantOn,
                                         input logic [NUM_BASE_SRC-1:0] base,
                                         input logic core);
        ccn_step_t res;
        logic      curLvl;
        logic      newLvl;
        res    = cur;
        curLvl = srcAt(base, core, cur.idx);
        newLvl = srcAt(base, core, want);
        if (!curLvl && !newLvl) begin
            res.idx = want;
        end
        if (!curLvl) begin
            res.gate = wantOn;
        end
        return res;
    endfunction

    function automatic logic pairLegal(input logic [4:0] idx, input logic vert);
        logic [4:0] k;
        logic       ok;
        k  = idx - SRC_PLL_BASE;
        ok = 1'b0;
        if (idx <= SRC_LR_HI) begin
            ok = vert;
        end else if (idx <= SRC_TB_HI) begin
            ok = !vert;
        end else if (idx < SRC_CORE) begin
            ok = !CORNER_PLL_MASK[k[2:1]] && (vert == FAST_PLL_MASK[k[2:1]]);
        end else if (idx == SRC_CORE) begin
            ok = 1'b1;
        end
        return ok;
    endfunction

    function automatic ccn_dec_t decode(input logic [ADDR_W-1:0] a);
        ccn_dec_t d;
        d.kind = K_NONE;
        d.idx  = a[6:2];
        if (a[1:0] != 2'h0 || a >= OFS_END) begin
            d.kind = K_NONE;
        end else if (a >= OFS_RSTAT) begin
            d.kind = K_RSTAT;
        end else if (a >= OFS_GSTAT) begin
            d.kind = K_GSTAT;
        end else if (a >= OFS_POUT) begin
            d.kind = (a < OFS_POUT + 12'h008) ? K_POUT : K_NONE;
            d.idx  = {4'h0, a[2]};
        end else if (a >= OFS_GRPSEL) begin
            d.kind = K_GRP;
            d.idx  = {3'h0, a[3:2]};
        end else if (a >= OFS_ROWSEL) begin
            d.kind = K_ROW;
            d.idx  = {3'h0, a[3:2]};
        end else if (a >= OFS_PAIR) begin
            d.kind = K_PAIR;
            d.idx  = {3'h0, a[3:2]};
        end else if (a >= OFS_RSEL) begin
            d.kind = K_RSEL;
            d.idx  = 5'(a[7:2] - 6'h10);
        end else begin
            d.kind = K_GSEL;
            d.idx  = {1'b0, a[5:2]};
        end
        return d;
    endfunction

    // ********************************
    // Input synchroniser
    // ********************************
    ccn_in_t syncA_ff;
    ccn_in_t syncB_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            syncA_ff <= '0;
            syncB_ff <= '0;
        end else begin
            syncA_ff <= srcIn;
            syncB_ff <= syncA_ff;
        end
    end

    logic [NUM_BASE_SRC-1:0] baseSrc;
    assign baseSrc = {syncB_ff.pllOut, syncB_ff.clkPin};

    // ********************************
    // Configuration registers and APB
    // ********************************
    ccn_gcfg_t   gCfg_ff   [NUM_GLOBAL];
    ccn_rcfg_t   rCfg_ff   [NUM_REGIONAL];
    ccn_pair_t   pair_ff   [NUM_PAIR];
    ccn_rowsel_t rowSel_ff [NUM_QUAD];
    ccn_grpsel_t grpSel_ff [NUM_QUAD];
    ccn_pout_t   pout_ff   [NUM_PINOUT];
    logic [31:0] prdata_ff;
    ccn_dec_t    dec;
    logic        access;
    logic        wrEn;
    logic        isStat;
    logic [NUM_GLOBAL-1:0]   gGateVec;
    logic [NUM_REGIONAL-1:0] rGateVec;

    assign dec     = decode(paddr);
    assign access  = psel && penable;
    assign isStat  = (dec.kind == K_GSTAT) || (dec.kind == K_RSTAT);
    // Configuration is closed once the device runs in user mode
    assign pslverr = access && ((dec.kind == K_NONE)
                     || (pwrite && (isStat || syncB_ff.userMode)));
    assign pready  = access;
    assign wrEn    = access && pwrite && !pslverr;
    assign prdata  = prdata_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_GLOBAL; i++) begin
                gCfg_ff[i] <= '0;
            end
            for (int i = 0; i < NUM_REGIONAL; i++) begin
                rCfg_ff[i] <= '0;
            end
            for (int i = 0; i < NUM_PAIR; i++) begin
                pair_ff[i] <= '0;
            end
            for (int i = 0; i < NUM_QUAD; i++) begin
                rowSel_ff[i] <= '0;
                grpSel_ff[i] <= '0;
            end
            for (int i = 0; i < NUM_PINOUT; i++) begin
                pout_ff[i] <= '0;
            end
        end else if (wrEn) begin
            unique case (dec.kind)
                K_GSEL:  gCfg_ff[dec.idx[3:0]]   <= pwdata[$bits(ccn_gcfg_t)-1:0];
                K_RSEL:  rCfg_ff[dec.idx]        <= pwdata[$bits(ccn_rcfg_t)-1:0];
                K_PAIR:  pair_ff[dec.idx[1:0]]   <= pwdata[$bits(ccn_pair_t)-1:0];
                K_ROW:   rowSel_ff[dec.idx[1:0]] <= pwdata[$bits(ccn_rowsel_t)-1:0];
                K_GRP:   grpSel_ff[dec.idx[1:0]] <= pwdata[$bits(ccn_grpsel_t)-1:0];
                K_POUT:  pout_ff[dec.idx[0]]     <= pwdata[$bits(ccn_pout_t)-1:0];
                K_NONE, K_GSTAT, K_RSTAT: ;
            endcase
        end
    end

    // Read data is fetched in the setup cycle so it stands from a flip-flop
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            prdata_ff <= '0;
        end else if (psel && !penable) begin
            unique case (dec.kind)
                K_GSEL:  prdata_ff <= 32'(gCfg_ff[dec.idx[3:0]]);
                K_RSEL:  prdata_ff <= 32'(rCfg_ff[dec.idx]);
                K_PAIR:  prdata_ff <= 32'(pair_ff[dec.idx[1:0]]);
                K_ROW:   prdata_ff <= 32'(rowSel_ff[dec.idx[1:0]]);
                K_GRP:   prdata_ff <= 32'(grpSel_ff[dec.idx[1:0]]);
                K_POUT:  prdata_ff <= 32'(pout_ff[dec.idx[0]]);
                K_GSTAT: prdata_ff <= 32'(gGateVec);
                K_RSTAT: prdata_ff <= rGateVec;
                K_NONE:  prdata_ff <= '0;
            endcase
        end
    end

    // ********************************
    // Global nets
    // ********************************
    ccn_step_t gSt_ff  [NUM_GLOBAL];
    ccn_step_t nxt_gSt [NUM_GLOBAL];
    logic [4:0]            gWant   [NUM_GLOBAL];
    logic [NUM_GLOBAL-1:0] gWantOn;
    logic [NUM_GLOBAL-1:0] gLvl;
    logic [NUM_GLOBAL-1:0] globalNet_ff;

    always_comb begin
        for (int g = 0; g < NUM_GLOBAL; g++) begin
            gWant[g] = gCfg_ff[g].sel;
            if (gCfg_ff[g].dynMode) begin
                gWant[g] = syncB_ff.gDynSel[g] ? gCfg_ff[g].dynB : gCfg_ff[g].dynA;
            end
            gWantOn[g] = gCfg_ff[g].on && syncB_ff.gDynEn[g];
            nxt_gSt[g] = ccStep(gSt_ff[g], gWant[g], gWantOn[g], baseSrc,
                                syncB_ff.coreGlobal[g]);
            gLvl[g]     = srcAt(baseSrc, syncB_ff.coreGlobal[g], gSt_ff[g].idx);
            gGateVec[g] = gSt_ff[g].gate;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int g = 0; g < NUM_GLOBAL; g++) begin
                gSt_ff[g] <= '0;
            end
            globalNet_ff <= '0;
        end else begin
            for (int g = 0; g < NUM_GLOBAL; g++) begin
                gSt_ff[g] <= nxt_gSt[g];
            end
            globalNet_ff <= gLvl & gGateVec;
        end
    end

    // ********************************
    // Regional nets and quadrant pairs
    // ********************************
    ccn_step_t rSt_ff  [NUM_REGIONAL];
    ccn_step_t nxt_rSt [NUM_REGIONAL];
    logic [4:0]              rWant [NUM_REGIONAL];
    logic [NUM_REGIONAL-1:0] rWantOn;
    logic [NUM_REGIONAL-1:0] rLvl;
    logic [NUM_REGIONAL-1:0] regionalNet_ff;
    logic [NUM_PAIR-1:0]     pairOk;

    always_comb begin
        for (int p = 0; p < NUM_PAIR; p++) begin
            pairOk[p] = pair_ff[p].en && pairLegal(pair_ff[p].src, PAIR_VERT[p]);
        end
        for (int r = 0; r < NUM_REGIONAL; r++) begin
            rWant[r]   = rCfg_ff[r].sel;
            // Side pins are not wired to the regional selector
            rWantOn[r] = rCfg_ff[r].on && (rCfg_ff[r].sel >= SRC_TB_LO)
                         && (rCfg_ff[r].sel <= SRC_CORE);
            for (int p = 0; p < NUM_PAIR; p++) begin
                if (pairOk[p] && (pair_ff[p].line == 3'(r % QUAD_LINES))
                    && ((PAIR_QA[p] == 2'(r / QUAD_LINES))
                    || (PAIR_QB[p] == 2'(r / QUAD_LINES)))) begin
                    rWant[r]   = pair_ff[p].src;
                    rWantOn[r] = 1'b1;
                end
            end
            rWantOn[r] = rWantOn[r] && syncB_ff.rDynEn[r];
            nxt_rSt[r] = ccStep(rSt_ff[r], rWant[r], rWantOn[r], baseSrc,
                                syncB_ff.coreRegional[r]);
            rLvl[r]     = srcAt(baseSrc, syncB_ff.coreRegional[r], rSt_ff[r].idx);
            rGateVec[r] = rSt_ff[r].gate;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int r = 0; r < NUM_REGIONAL; r++) begin
                rSt_ff[r] <= '0;
            end
            regionalNet_ff <= '0;
        end else begin
            for (int r = 0; r < NUM_REGIONAL; r++) begin
                rSt_ff[r] <= nxt_rSt[r];
            end
            regionalNet_ff <= rLvl & rGateVec;
        end
    end

    // ********************************
    // Row clocks and logic row groups
    // ********************************
    logic [QUAD_RES-1:0]                qRes   [NUM_QUAD];
    logic [ROW_CLKS-1:0]                rowClk [NUM_QUAD];
    logic [NUM_QUAD*GROUP_CLKS-1:0]     grpClk_ff;
    logic [NUM_QUAD*GROUP_CLKS-1:0]     nxt_grpClk;

    always_comb begin
        for (int q = 0; q < NUM_QUAD; q++) begin
            qRes[q] = {regionalNet_ff[q*QUAD_LINES +: QUAD_LINES], globalNet_ff};
            for (int k = 0; k < ROW_CLKS; k++) begin
                rowClk[q][k] = (rowSel_ff[q][k] < 5'(QUAD_RES)) ? qRes[q][rowSel_ff[q][k]]
                                                               : 1'b0;
            end
            for (int j = 0; j < GROUP_CLKS; j++) begin
                nxt_grpClk[q*GROUP_CLKS+j] = (grpSel_ff[q][j] < 3'(ROW_CLKS))
                                             ? rowClk[q][grpSel_ff[q][j]] : 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            grpClk_ff <= '0;
        end else begin
            grpClk_ff <= nxt_grpClk;
        end
    end

    // ********************************
    // PLL output pins
    // ********************************
    ccn_step_t pSt_ff  [NUM_PINOUT];
    ccn_step_t nxt_pSt [NUM_PINOUT];
    logic [NUM_PINOUT-1:0] pNet;
    logic [NUM_PINOUT-1:0] pllPin_ff;

    always_comb begin
        for (int i = 0; i < NUM_PINOUT; i++) begin
            nxt_pSt[i] = ccStep(pSt_ff[i], SRC_PLL_BASE + 5'(pout_ff[i].sel),
                                pout_ff[i].on && syncB_ff.pDynEn[i], baseSrc,
                                1'b0);
            pNet[i] = srcAt(baseSrc, 1'b0, pSt_ff[i].idx) && pSt_ff[i].gate;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_PINOUT; i++) begin
                pSt_ff[i] <= '0;
            end
            pllPin_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_PINOUT; i++) begin
                pSt_ff[i] <= nxt_pSt[i];
                pllPin_ff[i] <= pout_ff[i].useInternal ? syncB_ff.pinInternal[i]
                                                       : pNet[i];
            end
        end
    end

    assign globalClockNet   = globalNet_ff;
    assign regionalClockNet = regionalNet_ff;
    assign logicRowGroupClk = grpClk_ff;
    assign pllPin           = pllPin_ff;

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    a_gnet_off_low: assert property (globalNet_ff == ($past(gLvl) & $past(gGateVec)))
        else $error("global net high while gated off");
    a_rnet_off_low: assert property ((regionalNet_ff & ~$past(rGateVec)) == '0)
        else $error("regional net high while gated off");
    a_gate_on_low: assert property (((gGateVec ^ $past(gGateVec)) & $past(gLvl)) == '0)
        else $error("global gate moved during high phase");
    // A gate may stay open past a dropped enable until its source goes low
    a_static_off: assert property (((gGateVec & ~$past(gGateVec) & ~$past(gWantOn)) == '0))
        else $error("global gate opened without enable");
    a_reg_side_pin: assert property ((!rGateVec[0] && rCfg_ff[0].sel < SRC_TB_LO
                                      && !pairOk[0] && !pairOk[2]) |=> !rGateVec[0])
        else $error("regional net gated on from side pin");
    a_cfg_locked: assert property ((access && pwrite && syncB_ff.userMode) |-> pslverr
                                   ##1 ($stable(gCfg_ff[0]) && $stable(rCfg_ff[0])
                                   && $stable(pout_ff[0])))
        else $error("configuration changed in user mode");
    a_dyn_two_in: assert property ((gCfg_ff[0].dynMode && gSt_ff[0].idx != $past(gSt_ff[0].idx))
                                   |-> (gSt_ff[0].idx == $past(gCfg_ff[0].dynA)
                                   || gSt_ff[0].idx == $past(gCfg_ff[0].dynB)))
        else $error("dynamic select left its two inputs");
    a_corner_pair: assert property ((pair_ff[1].en && pair_ff[1].src == 5'h13) |-> !pairOk[1])
        else $error("corner PLL accepted for pair");
    a_pin_internal: assert property (pout_ff[0].useInternal && $past(pout_ff[0].useInternal)
                                     |-> pllPin_ff[0] == $past(syncB_ff.pinInternal[0]))
        else $error("PLL pin ignored internal signal");

    c_dyn_switch: cover property (gCfg_ff[0].dynMode ##1 $changed(gSt_ff[0].idx));
    c_gate_close: cover property ($fell(gGateVec[0]));
    c_pair_live:  cover property (pairOk[0] && rGateVec[0] && rGateVec[8]);
    c_wr_refused: cover property (access && pslverr);

endmodule

`default_nettype wire

/* test/ccn_user_logic.sv */
// Purpose: Far side model: clock sources and the dynamic controls of user logic
// Assumes: Sources are periodic from reset so bench window counts are exact
// Notes:   Pins run at 8 cycles a period, PLL outputs at 4, logic at 16
`timescale 1ns/1ps
`default_nettype none

module ccn_user_logic
    import ccn_pkg::*;
(
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  lockCfg,
    input  wire logic [NUM_GLOBAL-1:0] dynSel,
    input  wire logic [NUM_GLOBAL-1:0] dynEn,
    output var  ccn_in_t               srcIn
);
    logic [3:0] phase_ff;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= 4'h0;
        end else begin
            phase_ff <= phase_ff + 4'h1;
        end
    end

    // Controls change only after clk_sys edges, as real user logic would
    always_comb begin
        srcIn              = '0;
        srcIn.clkPin       = {NUM_PIN{phase_ff[2]}};
        srcIn.pllOut       = {NUM_PLL_OUT{phase_ff[1]}};
        srcIn.coreGlobal   = {NUM_GLOBAL{phase_ff[3]}};
        srcIn.coreRegional = {NUM_REGIONAL{phase_ff[3]}};
        srcIn.gDynSel      = dynSel;
        srcIn.gDynEn       = dynEn;
        srcIn.rDynEn       = '1;
        srcIn.pDynEn       = '1;
        srcIn.pinInternal  = {NUM_PINOUT{phase_ff[0]}};
        srcIn.userMode     = lockCfg;
    end
endmodule

`default_nettype wire

/* test/ccn_clock_network_control_test.sv */
// Purpose: Self-checking bench of the clock network control block
// Assumes: Zero wait APB slave; nets rebuilt at the clk_sys rate
// Notes:   Rising edges of one watched net output are counted over 80 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("Error %0t: got %h want %h", $time, (a), (b)); end end

module ccn_clock_network_control_test;
    import ccn_pkg::*;
    logic                  clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic                  lockCfg = 0, measDone = 0, pready, pslverr;
    logic [ADDR_W-1:0]     paddr = '0;
    logic [31:0]           pwdata = '0, prdata, measCnt, rnd;
    logic [NUM_GLOBAL-1:0] dynSel = '0, dynEn = '0, gNet;
    logic [33:0]           expQ[$], monE;
    logic [NUM_REGIONAL-1:0]        rNet;
    logic [NUM_QUAD*GROUP_CLKS-1:0] grpClk;
    logic [NUM_PINOUT-1:0]          pPin;
    logic [61:0]                    obs;
    ccn_in_t               srcIn;
    int                    bad_count = 0, cmp_count = 0;

    always #50 clk_sys = ~clk_sys;

    ccn_user_logic PART (.clk_sys(clk_sys), .nrst(nrst), .lockCfg(lockCfg),
        .dynSel(dynSel), .dynEn(dynEn), .srcIn(srcIn));
    ccn_clock_network_control DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .srcIn(srcIn),
        .globalClockNet(gNet), .regionalClockNet(rNet), .logicRowGroupClk(grpClk),
        .pllPin(pPin));

    // Watched bits: globals 0-15, regionals 16-47, row groups 48-59, PLL pins 60-61
    assign obs = {pPin, grpClk, rNet, gNet};

    task automatic finish_test;
        $display("Checks %0d, errors %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Note layout: bit 33 compare data, bit 32 error flag, then data
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d, input logic [33:0] e);
        int n;
        expQ.push_back(e);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            bad_count++;
            finish_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Settle time covers synchroniser and the low-phase gate opening
    task automatic meas(input int b, input logic [31:0] want);
        logic p;
        repeat (20) @(posedge clk_sys);
        measCnt = 0;
        p = obs[b];
        repeat (80) begin
            @(posedge clk_sys);
            measCnt += 32'(obs[b] & ~p);
            p = obs[b];
        end
        expQ.push_back({2'b00, want});
        measDone <= 1'b1;
        @(posedge clk_sys);
        measDone <= 1'b0;
    endtask

    always @(posedge clk_sys) begin
        if (psel && penable && pready) begin
            monE = expQ.pop_front();
            if (monE[33]) begin
                `CHK({pslverr, prdata}, monE[32:0])
            end else begin
                `CHK(pslverr, monE[32])
            end
        end
        if (measDone) begin
            monE = expQ.pop_front();
            `CHK(measCnt, monE[31:0])
        end
    end

    initial begin
        void'($urandom(65689));
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, OFS_GSEL, 32'h0, {2'b10, 32'h0});
        apb(1'b0, OFS_GSTAT, 32'h0, {2'b10, 32'h0});
        apb(1'b0, OFS_END, 32'h0, 34'h3_0000_0000);
        apb(1'b1, OFS_GSTAT, 32'hF, 34'h1_0000_0000);
        rnd = $urandom & 32'h3F;
        apb(1'b1, OFS_RSEL + 12'h4, rnd, 34'h0);
        apb(1'b0, OFS_RSEL + 12'h4, 32'h0, {2'b10, rnd});
        dynEn <= 16'h0001;
        apb(1'b1, OFS_GSEL, 32'h0001_0004, 34'h0);
        meas(0, 32'hA);
        dynEn <= 16'h0000;
        meas(0, 32'h0);
        dynEn <= 16'h0001;
        apb(1'b1, OFS_GSEL, 32'h0000_0004, 34'h0);
        meas(0, 32'h0);
        apb(1'b1, OFS_GSEL, 32'h0001_B080, 34'h0);
        meas(0, 32'hA);
        dynSel <= 16'h0001;
        meas(0, 32'h14);
        apb(1'b1, OFS_RSEL, 32'h24, 34'h0);
        meas(16, 32'hA);
        apb(1'b1, OFS_ROWSEL, 32'h200, 34'h0);
        apb(1'b1, OFS_GRPSEL, 32'h1, 34'h0);
        meas(48, 32'hA);
        apb(1'b1, OFS_RSEL, 32'h20, 34'h0);
        meas(16, 32'h0);
        apb(1'b1, OFS_PAIR + 12'h4, 32'h131, 34'h0);
        meas(32, 32'h0);
        apb(1'b1, OFS_PAIR + 12'h4, 32'h41, 34'h0);
        meas(32, 32'hA);
        apb(1'b1, OFS_POUT, 32'h8, 34'h0);
        meas(60, 32'h14);
        apb(1'b1, OFS_POUT, 32'h18, 34'h0);
        meas(60, 32'h28);
        lockCfg <= 1'b1;
        repeat (5) @(posedge clk_sys);
        apb(1'b1, OFS_GSEL, 32'h0, 34'h1_0000_0000);
        dynSel <= 16'h0000;
        meas(0, 32'hA);
        finish_test();
    end
endmodule

`default_nettype wire
